//--- rtl/lef_map.vh
// Register map, field positions and reset values of the limit event flag block
`ifndef LEF_MAP_VH
`define LEF_MAP_VH
`define LEF_IDX_STAT     10'h041
`define LEF_IDX_VEN      10'h07e
`define LEF_IDX_TEN      10'h082
`define LEF_IDX_IRQ_STAT 10'h0c0
`define LEF_IDX_IRQ_MASK 10'h0c1
`define LEF_BIT_AUX      1
`define LEF_BIT_MAIN     2
`define LEF_BIT_RD1      4
`define LEF_BIT_INT      5
`define LEF_BIT_RD2      6
`define LEF_BIT_SUM      7
`define LEF_RST_BYTE     8'h00
`define LEF_RST_WORD     32'h0000_0000
`define LEF_TRANS_NSEQ   1'b1
`define LEF_NCH          5
`endif

//--- rtl/lef_limit_event_flags.v
// Limit event flag register one with AHB-Lite slave and interrupt logic
`timescale 1ns/10ps
`include "lef_map.vh"
module lef_limit_event_flags #(
  parameter W = 8
) (
  input  wire                     CORE_CLK_I,
  input  wire                     RST_N_I,
  input  wire                     HSEL_I,
  input  wire [31:0]              HADDR_I,
  input  wire [1:0]               HTRANS_I,
  input  wire                     HWRITE_I,
  input  wire [2:0]               HSIZE_I,
  input  wire [31:0]              HWDATA_I,
  input  wire                     HREADY_I,
  output reg  [31:0]              HRDATA_O,
  output reg                      HREADYOUT_O,
  output reg                      HRESP_O,
  input  wire                     MON_START_I,
  input  wire [`LEF_NCH*W-1:0]    READING_I,
  input  wire [`LEF_NCH*W-1:0]    LOW_LIMIT_I,
  input  wire [`LEF_NCH*W-1:0]    HIGH_LIMIT_I,
  input  wire [`LEF_NCH-1:0]      READING_UPD_I,
  input  wire                     SECOND_REG_ANY_I,
  output reg                      IRQ_O
);

  // Channel order: aux supply, main supply, diode one, internal, diode two
  reg  [`LEF_NCH-1:0] flag_r;
  reg  [`LEF_NCH-1:0] flag_nxt;
  reg  [`LEF_NCH-1:0] viol_r;
  reg  [`LEF_NCH-1:0] cap_r;
  reg                 sum_r;
  reg  [7:0]          ven_r;
  reg  [7:0]          ten_r;
  reg  [7:0]          irq_r;
  reg  [7:0]          irq_nxt;
  reg  [7:0]          mask_r;
  reg                 rd_stat_r;
  reg                 wr_r;
  reg  [9:0]          waddr_r;
  wire [`LEF_NCH-1:0] en;
  wire [`LEF_NCH-1:0] viol;
  wire [`LEF_NCH-1:0] upd;
  wire [`LEF_NCH-1:0] ch_set;
  wire [`LEF_NCH-1:0] ch_dis;
  wire [7:0]          stat;
  wire [7:0]          ev;
  wire                take;
  wire [9:0]          idx;
  reg  [31:0]         rdata;

  // Enable sources per channel
  assign en = {ten_r[`LEF_BIT_RD2], ten_r[`LEF_BIT_INT], ten_r[`LEF_BIT_RD1],
               ven_r[`LEF_BIT_MAIN], ven_r[`LEF_BIT_AUX]};

  // No update is honoured while monitoring is stopped
  assign upd = READING_UPD_I & {`LEF_NCH{MON_START_I}};

  genvar k;
  generate
    for (k = 0; k < `LEF_NCH; k = k + 1) begin : g_ch
      wire [W-1:0] rd = READING_I[k*W +: W];
      wire [W-1:0] lo = LOW_LIMIT_I[k*W +: W];
      wire [W-1:0] hi = HIGH_LIMIT_I[k*W +: W];
      assign viol[k] = (rd <= lo) | (rd > hi);
    end
  endgenerate

  assign ch_set = upd & en & viol;
  assign ch_dis = upd & ~en;

  assign stat = {sum_r, flag_r[4], flag_r[3], flag_r[2], 1'b0,
                 flag_r[1], flag_r[0], 1'b0};

  assign ev = {SECOND_REG_ANY_I & ~sum_r,
               ch_set[4] & ~flag_r[4], ch_set[3] & ~flag_r[3],
               ch_set[2] & ~flag_r[2], 1'b0,
               ch_set[1] & ~flag_r[1], ch_set[0] & ~flag_r[0], 1'b0};

  assign take = HSEL_I & HREADY_I & (HTRANS_I[1] == `LEF_TRANS_NSEQ);
  assign idx  = HADDR_I[11:2];

  always @* begin
    case (idx)
      `LEF_IDX_STAT:     rdata = {24'h000000, stat};
      `LEF_IDX_VEN:      rdata = {24'h000000, ven_r};
      `LEF_IDX_TEN:      rdata = {24'h000000, ten_r};
      `LEF_IDX_IRQ_STAT: rdata = {24'h000000, irq_r};
      `LEF_IDX_IRQ_MASK: rdata = {24'h000000, mask_r};
      default:           rdata = `LEF_RST_WORD;
    endcase
  end

  always @* begin
    flag_nxt = flag_r;
    if (rd_stat_r) begin
      flag_nxt = flag_nxt & ~(cap_r & ~viol_r);
    end
    flag_nxt = flag_nxt & ~ch_dis;
    // Set wins over any clear
    flag_nxt = flag_nxt | ch_set;
  end

  always @* begin
    irq_nxt = irq_r;
    if (wr_r && waddr_r == `LEF_IDX_IRQ_STAT) begin
      irq_nxt = irq_nxt & ~HWDATA_I[7:0];
    end
    irq_nxt = irq_nxt | ev;
  end

  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      flag_r      <= {`LEF_NCH{1'b0}};
      viol_r      <= {`LEF_NCH{1'b0}};
      cap_r       <= {`LEF_NCH{1'b0}};
      sum_r       <= 1'b0;
      ven_r       <= `LEF_RST_BYTE;
      ten_r       <= `LEF_RST_BYTE;
      irq_r       <= `LEF_RST_BYTE;
      mask_r      <= `LEF_RST_BYTE;
      rd_stat_r   <= 1'b0;
      wr_r        <= 1'b0;
      waddr_r     <= 10'h000;
      HRDATA_O    <= `LEF_RST_WORD;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      IRQ_O       <= 1'b0;
    end else begin
      // Flags move only on started updates and status reads
      flag_r <= flag_nxt;
      viol_r <= (viol_r & ~upd) | (viol & upd);
      sum_r  <= SECOND_REG_ANY_I;
      irq_r  <= irq_nxt;
      IRQ_O  <= |(irq_nxt & mask_r);
      // Zero wait state: every transfer completes in its data phase
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      wr_r        <= take & HWRITE_I;
      waddr_r     <= idx;
      rd_stat_r   <= take & ~HWRITE_I & (idx == `LEF_IDX_STAT);
      cap_r       <= flag_r;
      if (take & ~HWRITE_I) begin
        HRDATA_O <= rdata;
      end
      if (wr_r) begin
        case (waddr_r)
          `LEF_IDX_VEN:      ven_r  <= HWDATA_I[7:0];
          `LEF_IDX_TEN:      ten_r  <= HWDATA_I[7:0];
          `LEF_IDX_IRQ_MASK: mask_r <= HWDATA_I[7:0];
          default:           ven_r  <= ven_r;
        endcase
      end
    end
  end

  // No group enable input exists here
endmodule

//--- dv/lef_limit_monitor.sv
// Port checker of the limit event flag register
`timescale 1ns/10ps
`include "lef_map.vh"
module lef_limit_monitor (
  input logic                CORE_CLK_I,
  input logic                RST_N_I,
  input logic                HSEL_I,
  input logic [31:0]         HADDR_I,
  input logic [1:0]          HTRANS_I,
  input logic                HWRITE_I,
  input logic                HREADY_I,
  input logic [31:0]         HRDATA_O,
  input logic                HREADYOUT_O,
  input logic                HRESP_O,
  input logic                MON_START_I,
  input logic [`LEF_NCH-1:0] READING_UPD_I,
  input logic                SECOND_REG_ANY_I,
  input logic                IRQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire tk = HSEL_I && HREADY_I && HTRANS_I[1];
  wire rd = tk && !HWRITE_I;
  wire wt = tk && HWRITE_I;
  wire ev = (|READING_UPD_I && MON_START_I) || SECOND_REG_ANY_I || wt;
  sequence s_stat_rd;
    rd && HADDR_I[11:2] == `LEF_IDX_STAT;
  endsequence
  AST_BUS_OKAY: assert property (HREADYOUT_O && !HRESP_O) else $error("bus stall");
  AST_SUM_BIT:
    assert property (s_stat_rd |=> HRDATA_O[7] == $past(SECOND_REG_ANY_I, 2)) else $error("sum");
  AST_RSVD_ZERO:
    assert property (s_stat_rd |=> HRDATA_O[31:8] == 24'h0 && !HRDATA_O[3] && !HRDATA_O[0])
      else $error("rsvd");
  AST_RD_HOLD: assert property (!rd |=> $stable(HRDATA_O)) else $error("hold");
  AST_UNMAP: assert property (rd && HADDR_I[11:2] == 10'h010 |=> HRDATA_O == 32'h0)
    else $error("unmap");
  // Irq only rises one to three cycles after an update, summary or write
  AST_IRQ_CAUSE:
    assert property ($rose(IRQ_O) |-> $past(ev) || $past(ev, 2) || $past(ev, 3)) else $error("irq");
  AST_IRQ_DROP: assert property ($fell(IRQ_O) |-> $past(wt, 2) || $past(wt, 3))
    else $error("drop");
  AST_IRQ_RST: assert property ($rose(RST_N_I) |-> !IRQ_O) else $error("irq rst");
endmodule
bind lef_limit_event_flags lef_limit_monitor i_lef_limit_monitor (.*);

//--- dv/test_limit_event_status_one.sv
// Self-checking bench of the limit event flag register
`timescale 1ns/10ps
`define CHK(n, a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, b, a); end end
module test_limit_event_status_one;
  logic        clk, rst_n, hsel, hwr, mon, sec, rdp;
  logic [1:0]  htr;
  logic [31:0] haddr, hwd, hrd, e, x;
  logic [39:0] rdg, lo, hi;
  logic [4:0]  upd;
  wire         hrdy, irq, hresp;
  logic [31:0] q[$];
  int          miscompares, comparisons;
  int          bp[5] = '{1, 2, 4, 5, 6};
  lef_limit_event_flags i_lef_limit_event_flags (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2),
    .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .MON_START_I(mon), .READING_I(rdg), .LOW_LIMIT_I(lo), .HIGH_LIMIT_I(hi),
    .READING_UPD_I(upd), .SECOND_REG_ANY_I(sec), .IRQ_O(irq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task test_done;
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for the ready edge
  task automatic hold;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!hrdy && n < 50);
    if (!hrdy) begin miscompares++; test_done; end
  endtask
  // Reads pass the expected word as d
  task automatic bus(input [31:0] a, input w, input [31:0] d);
    @(posedge clk);
    {hsel, htr, haddr, hwr} <= {1'b1, 2'h2, a, w};
    hold;
    {hsel, htr, hwd, rdp} <= {1'b0, 2'h0, d, !w};
    if (!w) q.push_back(d);
    hold;
    rdp <= 0;
  endtask
  task automatic up(input int k, input [7:0] v);
    @(posedge clk);
    rdg[k*8+:8] <= v;
    upd[k] <= 1;
    @(posedge clk);
    upd <= 0;
  endtask
  always @(posedge clk) if (rdp && hrdy) begin
    x = q.pop_front();
    `CHK("hrdata", hrd, x)
    `CHK("hresp", hresp, 1'b0)
  end
  initial begin
    {rst_n, hsel, hwr, mon, sec, rdp, htr, haddr, hwd, rdg, upd} = 0;
    lo = {5{8'h20}};
    hi = {5{8'hc0}};
    void'($urandom(3));
    repeat (2) @(posedge clk);
    {rst_n, mon} <= 2'b11;
    bus(32'h104, 0, 0);
    bus(32'h1f8, 1, 32'h06);
    bus(32'h208, 1, 32'h70);
    bus(32'h304, 1, 32'hf6);
    e = 0;
    for (int k = 0; k < 5; k++) up(k, k[0] ? 8'hc0 : 8'h21);
    bus(32'h104, 0, 0);
    for (int k = 0; k < 5; k++) begin
      up(k, k[0] ? 8'hc1 : 8'h20);
      up(k, 8'(8'h21 + $urandom % 8'ha0));
      e[bp[k]] = 1;
    end
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b1)
    bus(32'h104, 0, e);
    bus(32'h104, 0, 0);
    bus(32'h300, 1, 32'hff);
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b0)
    up(0, 8'h20);
    bus(32'h104, 1, 32'hff);
    bus(32'h104, 0, 32'h02);
    bus(32'h1f8, 1, 0);
    bus(32'h104, 0, 32'h02);
    up(0, 8'h20);
    bus(32'h104, 0, 0);
    bus(32'h1f8, 1, 32'h06);
    up(1, 8'h20);
    mon <= 0;
    bus(32'h1f8, 1, 0);
    up(1, 8'h20);
    up(2, 8'h20);
    bus(32'h104, 0, 32'h04);
    mon <= 1;
    up(1, 8'h50);
    bus(32'h104, 0, 0);
    bus(32'h304, 1, 0);
    sec <= 1;
    bus(32'h104, 0, 32'h80);
    `CHK("irq", irq, 1'b0)
    sec <= 0;
    bus(32'h104, 0, 0);
    bus(32'h040, 0, 0);
    test_done;
  end
endmodule
